// [include/rbt_consts.vh]
`ifndef RBT_CONSTS_VH
`define RBT_CONSTS_VH

// Data path shape
`define RBT_HALF_W    8
`define RBT_HALVES    2
`define RBT_BUS_W     16

// Reset values
`define RBT_DATA_RST  8'h00
`define RBT_OE_RST    8'h00
`define RBT_CTRL_RST  1'h0

`endif

// [verilog/rbt_transceiver.v]
// Functional notes
// - Sixteen-bit path, usable as two independent byte halves or one combined word.
// - A port captured on A-to-B clock rise, B port on B-to-A clock rise.
// - Capture ignores drive-allow and flow-sense; every rising edge stores port level.
// - Drive-allow high drives neither port; registers load independently or hold.
// - Drive-allow low drives one port: flow-sense low drives A, high drives B.
// - A-side select low passes live B input to A outputs.
// - A-side select high drives A outputs from the B-side register.
// - B-side select low passes live A input to B outputs.
// - B-side select high drives B outputs from the A-side register.
// - Within one half, both ports are never driven at the same time.
// - Switching source select gives no decoding glitch at driven outputs.
// - Undriven port still accepts data into either or both registers.
// - Disabled port keeps its input path for capture and stored forwarding.
// - Port direction depends only on drive-allow and flow-sense, never clocks.
`timescale 1ns/1ns
`include "rbt_consts.vh"

module rbt_transceiver (
  // Clock and reset
  input  wire                      ref_clk_in,
  input  wire                      sys_rst_in,
  // Per-half controls
  input  wire [`RBT_HALVES-1:0]    drive_allow_n_in,
  input  wire [`RBT_HALVES-1:0]    flow_sense_in,
  input  wire [`RBT_HALVES-1:0]    a_to_b_capture_clock_in,
  input  wire [`RBT_HALVES-1:0]    b_to_a_capture_clock_in,
  input  wire [`RBT_HALVES-1:0]    a_side_source_select_in,
  input  wire [`RBT_HALVES-1:0]    b_side_source_select_in,
  // A port
  input  wire [`RBT_BUS_W-1:0]     a_port_lines_in,
  output wire [`RBT_BUS_W-1:0]     a_port_lines_out,
  output wire [`RBT_BUS_W-1:0]     a_port_lines_oe_out,
  // B port
  input  wire [`RBT_BUS_W-1:0]     b_port_lines_in,
  output wire [`RBT_BUS_W-1:0]     b_port_lines_out,
  output wire [`RBT_BUS_W-1:0]     b_port_lines_oe_out,
  // Stored contents
  output wire [`RBT_BUS_W-1:0]     a_side_store_out,
  output wire [`RBT_BUS_W-1:0]     b_side_store_out
);

  // Direction modes of one half
  localparam [1:0] MODE_ISOLATE = 2'h0;
  localparam [1:0] MODE_DRIVE_A = 2'h1;
  localparam [1:0] MODE_DRIVE_B = 2'h2;

  genvar h;

  generate
    for (h = 0; h < `RBT_HALVES; h = h + 1) begin : g_half
      // Live port levels and controls of this half
      wire [`RBT_HALF_W-1:0] a_live;
      wire [`RBT_HALF_W-1:0] b_live;
      wire                   allow_n;
      wire                   flow;
      wire                   a_sel;
      wire                   b_sel;
      wire                   a_clk_now;
      wire                   b_clk_now;

      // Capture edge flags
      reg                    a_rise;
      reg                    b_rise;

      // Capture clock history
      reg                    a_clk_prev_ff;
      reg                    b_clk_prev_ff;
      reg                    nxt_a_clk_prev;
      reg                    nxt_b_clk_prev;

      // Storage registers
      reg  [`RBT_HALF_W-1:0] a_store_ff;
      reg  [`RBT_HALF_W-1:0] b_store_ff;
      reg  [`RBT_HALF_W-1:0] nxt_a_store;
      reg  [`RBT_HALF_W-1:0] nxt_b_store;

      // Output registers
      reg  [`RBT_HALF_W-1:0] a_out_ff;
      reg  [`RBT_HALF_W-1:0] b_out_ff;
      reg  [`RBT_HALF_W-1:0] a_oe_ff;
      reg  [`RBT_HALF_W-1:0] b_oe_ff;

      // Direction decode and next outputs
      reg  [1:0]             dir_mode;
      reg                    drive_a;
      reg                    drive_b;
      reg  [`RBT_HALF_W-1:0] nxt_a_out;
      reg  [`RBT_HALF_W-1:0] nxt_b_out;
      reg  [`RBT_HALF_W-1:0] nxt_a_oe;
      reg  [`RBT_HALF_W-1:0] nxt_b_oe;

      // Slices of the shared ports
      assign a_live    = a_port_lines_in[h*`RBT_HALF_W +: `RBT_HALF_W];
      assign b_live    = b_port_lines_in[h*`RBT_HALF_W +: `RBT_HALF_W];
      assign allow_n   = drive_allow_n_in[h];
      assign flow      = flow_sense_in[h];
      assign a_sel     = a_side_source_select_in[h];
      assign b_sel     = b_side_source_select_in[h];
      assign a_clk_now = a_to_b_capture_clock_in[h];
      assign b_clk_now = b_to_a_capture_clock_in[h];

      // A capture clock edge detect
      always @* begin
        if (a_clk_now && !a_clk_prev_ff) begin
          a_rise = 1'h1;
        end else begin
          a_rise = 1'h0;
        end
      end

      // B capture clock edge detect
      always @* begin
        if (b_clk_now && !b_clk_prev_ff) begin
          b_rise = 1'h1;
        end else begin
          b_rise = 1'h0;
        end
      end

      // Capture clock history next values
      always @* begin
        nxt_a_clk_prev = a_clk_now;
      end

      always @* begin
        nxt_b_clk_prev = b_clk_now;
      end

      // A clock history
      always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          a_clk_prev_ff <= `RBT_CTRL_RST;
        end else begin
          a_clk_prev_ff <= nxt_a_clk_prev;
        end
      end

      // B clock history
      always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          b_clk_prev_ff <= `RBT_CTRL_RST;
        end else begin
          b_clk_prev_ff <= nxt_b_clk_prev;
        end
      end

      // Store next values, capture ignores drive-allow and flow-sense
      always @* begin
        if (a_rise) begin
          nxt_a_store = a_live;
        end else begin
          nxt_a_store = a_store_ff;
        end
      end

      always @* begin
        if (b_rise) begin
          nxt_b_store = b_live;
        end else begin
          nxt_b_store = b_store_ff;
        end
      end

      // A-side storage, deliberately without reset
      always @(posedge ref_clk_in) begin
        a_store_ff <= nxt_a_store;
      end

      // B-side storage, deliberately without reset
      always @(posedge ref_clk_in) begin
        b_store_ff <= nxt_b_store;
      end

      // Direction from drive-allow and flow-sense only
      always @* begin
        case ({allow_n, flow})
          2'h0: begin
            dir_mode = MODE_DRIVE_A;
          end
          2'h1: begin
            dir_mode = MODE_DRIVE_B;
          end
          2'h2: begin
            dir_mode = MODE_ISOLATE;
          end
          2'h3: begin
            dir_mode = MODE_ISOLATE;
          end
          default: begin
            dir_mode = MODE_ISOLATE;
          end
        endcase
      end

      // At most one port enabled per mode
      always @* begin
        case (dir_mode)
          MODE_DRIVE_A: begin
            drive_a = 1'h1;
            drive_b = 1'h0;
          end
          MODE_DRIVE_B: begin
            drive_a = 1'h0;
            drive_b = 1'h1;
          end
          MODE_ISOLATE: begin
            drive_a = 1'h0;
            drive_b = 1'h0;
          end
          default: begin
            drive_a = 1'h0;
            drive_b = 1'h0;
          end
        endcase
      end

      // A enables fan out to every line of the half
      always @* begin
        if (drive_a) begin
          nxt_a_oe = {`RBT_HALF_W{1'h1}};
        end else begin
          nxt_a_oe = {`RBT_HALF_W{1'h0}};
        end
      end

      // B enables fan out to every line of the half
      always @* begin
        if (drive_b) begin
          nxt_b_oe = {`RBT_HALF_W{1'h1}};
        end else begin
          nxt_b_oe = {`RBT_HALF_W{1'h0}};
        end
      end

      // A outputs from live B or the B-side store
      always @* begin
        if (a_sel) begin
          nxt_a_out = b_store_ff;
        end else begin
          nxt_a_out = b_live;
        end
      end

      // B outputs from live A or the A-side store
      always @* begin
        if (b_sel) begin
          nxt_b_out = a_store_ff;
        end else begin
          nxt_b_out = a_live;
        end
      end

      // Registered outputs, so select changes cannot glitch
      // A drive value
      always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          a_out_ff <= `RBT_DATA_RST;
        end else begin
          a_out_ff <= nxt_a_out;
        end
      end

      // B drive value
      always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          b_out_ff <= `RBT_DATA_RST;
        end else begin
          b_out_ff <= nxt_b_out;
        end
      end

      // A enables
      always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          a_oe_ff <= `RBT_OE_RST;
        end else begin
          a_oe_ff <= nxt_a_oe;
        end
      end

      // B enables
      always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
          b_oe_ff <= `RBT_OE_RST;
        end else begin
          b_oe_ff <= nxt_b_oe;
        end
      end

      // Port views of this half
      assign a_port_lines_out[h*`RBT_HALF_W +: `RBT_HALF_W]    = a_out_ff;
      assign b_port_lines_out[h*`RBT_HALF_W +: `RBT_HALF_W]    = b_out_ff;
      assign a_port_lines_oe_out[h*`RBT_HALF_W +: `RBT_HALF_W] = a_oe_ff;
      assign b_port_lines_oe_out[h*`RBT_HALF_W +: `RBT_HALF_W] = b_oe_ff;

      // Store views of this half
      assign a_side_store_out[h*`RBT_HALF_W +: `RBT_HALF_W]    = a_store_ff;
      assign b_side_store_out[h*`RBT_HALF_W +: `RBT_HALF_W]    = b_store_ff;
    end
  endgenerate

endmodule

// [bench/rbt_props.sv]
`timescale 1ns/1ns
`include "rbt_consts.vh"
module rbt_props (
  input wire                   ref_clk_in, sys_rst_in,
  input wire [`RBT_HALVES-1:0] drive_allow_n_in, flow_sense_in, a_to_b_capture_clock_in, b_to_a_capture_clock_in,
  input wire [`RBT_HALVES-1:0] a_side_source_select_in, b_side_source_select_in,
  input wire [`RBT_BUS_W-1:0]  a_port_lines_in, a_port_lines_out, a_port_lines_oe_out, a_side_store_out,
  input wire [`RBT_BUS_W-1:0]  b_port_lines_in, b_port_lines_out, b_port_lines_oe_out, b_side_store_out
);
  wire [1:0]  ea = ~drive_allow_n_in & ~flow_sense_in;
  wire [1:0]  eb = ~drive_allow_n_in & flow_sense_in;
  wire [15:0] sa = {{8{a_side_source_select_in[1]}}, {8{a_side_source_select_in[0]}}};
  wire [15:0] sb = {{8{b_side_source_select_in[1]}}, {8{b_side_source_select_in[0]}}};
  wire [15:0] va = (sa & b_side_store_out) | (~sa & b_port_lines_in);
  wire [15:0] vb = (sb & a_side_store_out) | (~sb & a_port_lines_in);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_rise_a; !a_to_b_capture_clock_in[0] ##1 a_to_b_capture_clock_in[0]; endsequence
  sequence s_rise_b; !b_to_a_capture_clock_in[1] ##1 b_to_a_capture_clock_in[1]; endsequence
  a_one_port: assert property ((a_port_lines_oe_out & b_port_lines_oe_out) == 16'h0000) else $error("both driven");
  a_a_enable: assert property (1 |=> a_port_lines_oe_out == $past({{8{ea[1]}}, {8{ea[0]}}})) else $error("A oe");
  a_b_enable: assert property (1 |=> b_port_lines_oe_out == $past({{8{eb[1]}}, {8{eb[0]}}})) else $error("B oe");
  a_a_data: assert property (1 |=> ((a_port_lines_out ^ $past(va)) & a_port_lines_oe_out) == 16'h0000) else $error("A out");
  a_b_data: assert property (1 |=> ((b_port_lines_out ^ $past(vb)) & b_port_lines_oe_out) == 16'h0000) else $error("B out");
  a_a_capture: assert property (s_rise_a |=> a_side_store_out[7:0] == $past(a_port_lines_in[7:0])) else $error("A st");
  a_b_capture: assert property (s_rise_b |=> b_side_store_out[15:8] == $past(b_port_lines_in[15:8])) else $error("B st");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst_in |-> (a_port_lines_oe_out | b_port_lines_oe_out) == 16'h0000)
    else $error("driven in reset");
endmodule

// [bench/rbt_bus_model.sv]
`timescale 1ns/1ns
module rbt_bus_model (
  input  wire [15:0] a_oe_in, a_out_in, b_oe_in, b_out_in, a_drv_in, b_drv_in,
  output wire [15:0] a_wire_out, b_wire_out
);
  // Far side yields only where the enables say so
  assign a_wire_out = (a_oe_in & a_out_in) | (~a_oe_in & a_drv_in);
  assign b_wire_out = (b_oe_in & b_out_in) | (~b_oe_in & b_drv_in);
endmodule

// [bench/rbt_transceiver_test.sv]
`timescale 1ns/1ns
module rbt_transceiver_test;
  reg        ref_clk_in = 1'h0, sys_rst_in = 1'h0;
  reg [1:0]  drive_allow_n_in = 2'h3, flow_sense_in = 2'h0, a_to_b_capture_clock_in = 2'h0, b_to_a_capture_clock_in = 2'h0;
  reg [1:0]  a_side_source_select_in = 2'h0, b_side_source_select_in = 2'h0;
  reg [15:0] a_drv = 16'h0000, b_drv = 16'h0000;
  wire [15:0] a_port_lines_in, a_port_lines_out, a_port_lines_oe_out, a_side_store_out;
  wire [15:0] b_port_lines_in, b_port_lines_out, b_port_lines_oe_out, b_side_store_out;
  integer    mismatches = 0, cmp_count = 0;
  always #20 ref_clk_in = ~ref_clk_in;
  rbt_transceiver i_rbt_transceiver (.*);
  rbt_bus_model i_rbt_bus_model (.a_oe_in(a_port_lines_oe_out), .a_out_in(a_port_lines_out),
    .b_oe_in(b_port_lines_oe_out), .b_out_in(b_port_lines_out), .a_drv_in(a_drv), .b_drv_in(b_drv),
    .a_wire_out(a_port_lines_in), .b_wire_out(b_port_lines_in));
  task chk(input [39:0] nm, input [15:0] exp, input [15:0] got);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Control word: allow_n, flow, a select, b select, a clock, b clock
  task go(input [11:0] c, input [15:0] a, input [15:0] b);
    @(posedge ref_clk_in);
    {drive_allow_n_in, flow_sense_in, a_side_source_select_in, b_side_source_select_in,
      a_to_b_capture_clock_in, b_to_a_capture_clock_in} <= c;
    a_drv <= a;
    b_drv <= b;
    @(posedge ref_clk_in);
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    $display("test %h done", c);
  endtask
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    sys_rst_in <= 1'h1;
    repeat (2) @(posedge ref_clk_in);
    sys_rst_in <= 0;
    go(12'hC0F, 16'h1234, 16'hABCD);
    chk("ast", 16'h1234, a_side_store_out);
    chk("bst", 16'hABCD, b_side_store_out);
    chk("oe", 16'h0000, a_port_lines_oe_out | b_port_lines_oe_out);
    go(12'h000, 16'h5555, 16'h0F0F);
    chk("aout", 16'h0F0F, a_port_lines_out);
    chk("aoe", 16'hFFFF, a_port_lines_oe_out);
    go(12'h0C0, 16'h5555, 16'h7777);
    chk("aout", 16'hABCD, a_port_lines_out);
    go(12'h300, 16'h9696, 16'h0000);
    chk("bout", 16'h9696, b_port_lines_out);
    chk("aoe", 16'h0000, a_port_lines_oe_out);
    go(12'h330, 16'h4242, 16'h0000);
    chk("bout", 16'h1234, b_port_lines_out);
    go(12'h33C, 16'h4242, 16'h0000);
    chk("ast", 16'h4242, a_side_store_out);
    chk("bout", 16'h4242, b_port_lines_out);
    go(12'h600, 16'hC3C3, 16'h0000);
    chk("boe", 16'hFF00, b_port_lines_oe_out);
    chk("bout", 16'hC3C3, b_port_lines_out & 16'hFF00 | 16'h00C3);
    complete_run;
  end
endmodule
bind rbt_transceiver rbt_props i_rbt_props (.*);
